// ==== hdl/stp_target.sv ====
/*
 Target end: phase sequencer with parity checking, retry recovery and
 logical unit screening. Assumes the bus interface on one side and a
 command executor on the user side answering each cmdValid once.
*/
// Operation
// - Check parity only when option and mode enabled
// - Parity checking enabled after reset
// - Completion-only data-out error: finish, check condition
// - Initiator accepts all data-in bytes despite errors
// - Sense data lost once sent
// - Unlimited retries; initiator aborts or resets
// - Message-out error: REQ again after ATN drops
// - Initiator resends all message bytes in order
// - Discard message bytes after error until ATN drops
// - Message parity error resends last message in
// - Command error: restore pointers, fetch CDB again
// - Initiator rewinds command pointer on restore
// - Data-out error: restore pointers, request data again
// - Initiator error in data-in: restore, resend data
// - Initiator error in status: restore, resend status
// - Identify LUN overrides CDB LUN; only unit 0
// - Inquiry to bad LUN: no-device data, good
// - Sense to bad LUN: illegal request 25h
// - Other commands to bad LUN: check condition
// - Bad LUN commands leave unit 0 sense alone, except a CDB parity error without messages
`timescale 1ns/1ns
`include "stp_consts.svh"
module stp_target import stp_pkg::*; (
	input  wire logic        ref_clk,
	input  wire logic        nrst,
	stp_bus_if.target        bus,
	input  wire logic        hwParOpt,
	input  wire logic        modeParWe,
	input  wire logic        modeParVal,
	output logic             parChkOn,
	output logic             cmdValid,
	output logic [47:0]      cmdCdb,
	input  wire logic        rspValid,
	input  wire logic [1:0]  rspDir,
	input  wire logic [15:0] rspLen,
	input  wire logic        rspCheck,
	input  wire logic [3:0]  rspKey,
	input  wire logic [7:0]  rspAsc,
	input  wire logic [7:0]  rspAscq,
	output logic [15:0]      dinIdx,
	input  wire logic [7:0]  dinByte,
	output logic             doutValid,
	output logic [7:0]       doutByte,
	output logic [15:0]      doutIdx,
	output logic             doutRestart
);
	logic [13:0] s1_q, s2_q;
	logic        hwS, rstS, selS, atnS, ackS, parS;
	logic [7:0]  datS;
	logic        modePar_q, chkEn, rxPerr, xGo, xDone, endHere, msgOk;
	stp_xst_t    xs_q;
	stp_tst_t    st_q, retPh_q, nxt_q, mNxt;
	stp_src_t    src_q;
	logic [7:0]  txByte_q, txNext, stat_q, msgI_q, mMsgI, dinVal;
	logic        txPar_q, msgSys_q, idSeen_q, firstMo_q, perr_q;
	logic [2:0]  idLun_q, curLun;
	logic [15:0] cnt_q, len_q;
	logic [7:0]  cdb_q [6];
	logic [3:0]  key_q;
	logic [7:0]  asc_q, ascq_q;
	logic        cmdEnd, cmdErr, parSense, bdrHit, cmdValid_q;

	// Sense byte layout shared by unit 0 and unsupported-unit reports
	function automatic logic [7:0] senseByte(input logic [15:0] i, input logic [3:0] k,
		input logic [7:0] a, input logic [7:0] q);
		case (i)
			16'h0000: senseByte = `STP_SNS_FMT;
			16'h0002: senseByte = {4'h0, k};
			16'h0007: senseByte = `STP_SNS_ADD;
			16'h000c: senseByte = a;
			16'h000d: senseByte = q;
			default:  senseByte = 8'h00;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Bus inputs are asynchronous: two flops before any logic
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			s1_q <= '0;
			s2_q <= '0;
		end else begin
			s1_q <= {hwParOpt, bus.rst, bus.sel, bus.atn, bus.ack, bus.par, bus.dat};
			s2_q <= s1_q;
		end
	end
	assign {hwS, rstS, selS, atnS, ackS, parS} = s2_q[13:8];
	assign datS = s2_q[7:0];

	// Mode parameter copy of the parity enable, on by default
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			modePar_q <= `STP_PAR_DFLT;
		end else if (modeParWe) begin
			modePar_q <= modeParVal;
		end
	end
	assign chkEn    = hwS & modePar_q;
	assign rxPerr   = chkEn & (parS != stp_odd(datS));
	assign parChkOn = chkEn;

	////////////////////////////////////////////////////////////////////////
	// Byte handshake: drive data a cycle ahead of REQ, hold until ACK falls
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			xs_q     <= X_IDLE;
			txByte_q <= 8'h00;
			txPar_q  <= 1'b1;
		end else if (rstS) begin
			xs_q <= X_IDLE;
		end else begin
			case (xs_q)
				X_IDLE: if (xGo) begin
					xs_q     <= X_SETUP;
					txByte_q <= txNext;
					txPar_q  <= stp_odd(txNext);
				end
				X_SETUP: xs_q <= X_REQ;
				X_REQ:   if (ackS) xs_q <= X_REL;
				X_REL:   if (!ackS) xs_q <= X_IDLE;
				default: xs_q <= X_IDLE;
			endcase
		end
	end
	assign xDone   = (xs_q == X_REQ) && ackS;
	assign endHere = (xs_q == X_IDLE) && (cnt_q == len_q);

	// Data-in byte source by command kind
	always_comb begin
		case (src_q)
			SRC_USER:  dinVal = dinByte;
			SRC_SENSE: dinVal = senseByte(cnt_q, key_q, asc_q, ascq_q);
			SRC_NOLUN: dinVal = senseByte(cnt_q, `STP_KEY_ILL, `STP_ASC_LUN, `STP_ASCQ_NONE);
			default:   dinVal = (cnt_q == 16'h0000) ? `STP_INQ_NOLUN : 8'h00;
		endcase
	end

	// Next byte request; a request starts only while the engine is idle
	always_comb begin
		xGo    = 1'b0;
		txNext = 8'h00;
		if (xs_q == X_IDLE && !rstS) begin
			case (st_q)
				T_MSGO, T_CMD: xGo = 1'b1; // Retry REQ also comes from here
				T_DOUT: xGo = (cnt_q != len_q);
				T_DIN: begin
					xGo    = (cnt_q != len_q);
					txNext = dinVal;
				end
				T_STAT: begin
					xGo    = 1'b1;
					txNext = stat_q;
				end
				T_MSGI: begin
					xGo    = 1'b1;
					txNext = msgI_q;
				end
				default: xGo = 1'b0;
			endcase
		end
	end

	// Effect of one clean message-out byte
	always_comb begin
		mNxt  = nxt_q;
		mMsgI = msgI_q;
		case (datS)
			`STP_MSG_MPE: mNxt = T_MSGI;
			`STP_MSG_IDE: begin
				mNxt  = T_MSGI;
				mMsgI = `STP_MSG_RP;
			end
			`STP_MSG_ABT, `STP_MSG_BDR: mNxt = T_FREE;
			default: mNxt = nxt_q;
		endcase
	end
	assign msgOk  = !perr_q && !rxPerr;
	assign bdrHit = (st_q == T_MSGO) && xDone && msgOk && (datS == `STP_MSG_BDR);
	assign curLun = idSeen_q ? idLun_q : cdb_q[1][7:5];
	assign cmdEnd = (st_q == T_CMD) && xDone && (cnt_q[2:0] == `STP_CDB_LAST);
	assign cmdErr = perr_q | rxPerr;
	assign parSense = !msgSys_q && (((st_q == T_DOUT) && endHere && perr_q) ||
		(cmdEnd && cmdErr));

	////////////////////////////////////////////////////////////////////////
	// Phase sequencer
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			st_q      <= T_FREE;
			retPh_q   <= T_CMD;
			nxt_q     <= T_CMD;
			src_q     <= SRC_USER;
			msgSys_q  <= 1'b0;
			idSeen_q  <= 1'b0;
			firstMo_q <= 1'b0;
			idLun_q   <= 3'h0;
			perr_q    <= 1'b0;
			cnt_q     <= 16'h0000;
			len_q     <= 16'h0000;
			stat_q    <= `STP_ST_GOOD;
			msgI_q    <= `STP_MSG_CC;
			for (int i = 0; i < 6; i++) cdb_q[i] <= 8'h00;
		end else if (rstS) begin
			st_q <= T_FREE; // Bus reset clears the nexus
		end else begin
			case (st_q)
				T_FREE: if (selS) begin
					msgSys_q  <= atnS;
					firstMo_q <= atnS;
					idSeen_q  <= 1'b0;
					perr_q    <= 1'b0;
					cnt_q     <= 16'h0000;
					retPh_q   <= T_CMD;
					nxt_q     <= T_CMD;
					st_q      <= atnS ? T_MSGO : T_CMD;
				end
				T_MSGO: if (xDone) begin
					if (rxPerr) perr_q <= 1'b1;
					if (msgOk) begin // Bytes after an error are dropped
						nxt_q  <= mNxt;
						msgI_q <= mMsgI;
						if (datS[`STP_MSG_ID_BIT] && firstMo_q) begin
							idSeen_q <= 1'b1;
							idLun_q  <= datS[2:0];
						end
					end
					if (!atnS) begin
						if (!msgOk) perr_q <= 1'b0; // Stay and REQ again, no limit
						else begin
							st_q      <= mNxt;
							firstMo_q <= 1'b0;
						end
					end
				end
				T_CMD: if (xDone) begin
					cdb_q[cnt_q[2:0]] <= datS;
					perr_q <= cmdErr;
					cnt_q  <= cnt_q + 16'h0001;
					if (cnt_q[2:0] == `STP_CDB_LAST) begin
						cnt_q  <= 16'h0000;
						perr_q <= 1'b0;
						if (cmdErr && msgSys_q) begin
							msgI_q  <= `STP_MSG_RP; // Whole CDB again after restore
							retPh_q <= T_CMD;
							st_q    <= T_MSGI;
						end else if (cmdErr) begin
							stat_q <= `STP_ST_CHK;
							st_q   <= T_STAT;
						end else if (curLun != 3'h0) begin
							stat_q <= `STP_ST_GOOD;
							st_q   <= T_DIN;
							if (cdb_q[0] == `STP_OP_INQ) begin
								src_q <= SRC_INQ;
								len_q <= `STP_INQ_LEN;
							end else if (cdb_q[0] == `STP_OP_SENSE) begin
								src_q <= SRC_NOLUN;
								len_q <= `STP_SNS_LEN;
							end else begin
								stat_q <= `STP_ST_CHK;
								st_q   <= T_STAT;
							end
						end else if (cdb_q[0] == `STP_OP_SENSE) begin
							src_q  <= SRC_SENSE;
							len_q  <= `STP_SNS_LEN;
							stat_q <= `STP_ST_GOOD;
							st_q   <= T_DIN;
						end else begin
							st_q <= T_EXEC;
						end
					end
				end
				T_EXEC: if (rspValid) begin
					stat_q <= rspCheck ? `STP_ST_CHK : `STP_ST_GOOD;
					len_q  <= rspLen;
					src_q  <= SRC_USER;
					st_q   <= (rspDir == 2'h1) ? T_DIN : ((rspDir == 2'h2) ? T_DOUT : T_STAT);
				end
				T_DOUT: if (xDone) begin
					cnt_q  <= cnt_q + 16'h0001;
					perr_q <= cmdErr; // Keep taking bytes after an error
				end else if (endHere) begin
					cnt_q  <= 16'h0000;
					perr_q <= 1'b0;
					st_q   <= T_STAT;
					if (perr_q && msgSys_q) begin
						msgI_q  <= `STP_MSG_RP;
						retPh_q <= T_DOUT;
						st_q    <= T_MSGI;
					end else if (perr_q) begin
						stat_q <= `STP_ST_CHK;
					end
				end
				T_DIN: if (xDone) begin
					cnt_q <= cnt_q + 16'h0001;
					if (msgSys_q && atnS) begin
						retPh_q <= T_DIN; // Resume point for a restore
						nxt_q   <= T_DIN;
						st_q    <= T_MSGO;
					end
				end else if (endHere) begin
					st_q <= T_STAT;
				end
				T_STAT: if (xDone) begin
					msgI_q <= `STP_MSG_CC;
					st_q   <= T_MSGI;
					if (msgSys_q && atnS) begin
						retPh_q <= T_STAT;
						nxt_q   <= T_MSGI;
						st_q    <= T_MSGO;
					end
				end
				T_MSGI: if (xDone) begin
					if (msgSys_q && atnS) begin
						nxt_q <= T_MSGI; // Same byte again on request
						st_q  <= T_MSGO;
					end else if (msgI_q == `STP_MSG_CC) begin
						st_q <= T_FREE;
					end else begin
						cnt_q <= 16'h0000; // Restart the phase from its first byte
						st_q  <= retPh_q;
					end
				end
				default: st_q <= T_FREE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Unit 0 sense store; unsupported units write it only through CDB parity sense
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			key_q  <= 4'h0;
			asc_q  <= 8'h00;
			ascq_q <= 8'h00;
		end else if (rstS || bdrHit) begin
			key_q  <= 4'h0;
			asc_q  <= 8'h00;
			ascq_q <= 8'h00;
		end else if (parSense) begin
			key_q  <= `STP_KEY_HW;
			asc_q  <= `STP_ASC_PAR;
			ascq_q <= `STP_ASCQ_NONE;
		end else if (st_q == T_EXEC && rspValid && rspCheck) begin
			key_q  <= rspKey;
			asc_q  <= rspAsc;
			ascq_q <= rspAscq;
		end else if (st_q == T_DIN && src_q == SRC_SENSE && endHere) begin
			key_q  <= 4'h0; // Cleared once sent, so a resend is empty
			asc_q  <= 8'h00;
			ascq_q <= 8'h00;
		end
	end

	// User-side strobes
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			cmdValid_q  <= 1'b0;
			doutValid   <= 1'b0;
			doutByte    <= 8'h00;
			doutIdx     <= 16'h0000;
			doutRestart <= 1'b0;
		end else begin
			cmdValid_q  <= cmdEnd && !cmdErr && (curLun == 3'h0) &&
				(cdb_q[0] != `STP_OP_SENSE);
			doutValid   <= (st_q == T_DOUT) && xDone;
			doutByte    <= datS;
			doutIdx     <= cnt_q;
			doutRestart <= (st_q == T_DOUT) && endHere && perr_q && msgSys_q;
		end
	end
	assign cmdValid = cmdValid_q;
	assign cmdCdb   = {cdb_q[0], cdb_q[1], cdb_q[2], cdb_q[3], cdb_q[4], cdb_q[5]};
	assign dinIdx   = cnt_q;

	// Bus drive; data only in target-to-initiator phases
	always_comb begin
		case (st_q)
			T_MSGO:  bus.phase = PH_MSGO;
			T_MSGI:  bus.phase = PH_MSGI;
			T_DIN:   bus.phase = PH_DIN;
			T_STAT:  bus.phase = PH_STAT;
			T_DOUT:  bus.phase = PH_DOUT;
			default: bus.phase = PH_CMD;
		endcase
	end
	assign bus.req  = (xs_q == X_REQ);
	assign bus.bsy  = (st_q != T_FREE);
	assign bus.tOe  = (xs_q != X_IDLE) && (st_q inside {T_DIN, T_STAT, T_MSGI});
	assign bus.tDat = txByte_q;
	assign bus.tPar = txPar_q;
endmodule

// ==== hdl/stp_consts.svh ====
/*
 Constants for the target-side parity recovery link: message, opcode,
 status and sense codes, transfer lengths and the clock period.
 Assumes inclusion by bare name from the design files.
*/
`ifndef STP_CONSTS_SVH
`define STP_CONSTS_SVH
`define STP_MSG_CC     8'h00
`define STP_MSG_RP     8'h03
`define STP_MSG_IDE    8'h05
`define STP_MSG_ABT    8'h06
`define STP_MSG_MPE    8'h09
`define STP_MSG_BDR    8'h0c
`define STP_MSG_ID_BIT 7
`define STP_OP_SENSE   8'h03
`define STP_OP_INQ     8'h12
`define STP_ST_GOOD    8'h00
`define STP_ST_CHK     8'h02
`define STP_KEY_HW     4'h4
`define STP_ASC_PAR    8'h47
`define STP_KEY_ILL    4'h5
`define STP_ASC_LUN    8'h25
`define STP_ASCQ_NONE  8'h00
`define STP_SNS_FMT    8'h70
`define STP_SNS_ADD    8'h06
`define STP_SNS_LEN    16'h000e
`define STP_INQ_NOLUN  8'h7f
`define STP_INQ_LEN    16'h0005
`define STP_CDB_LAST   3'h5
`define STP_PAR_DFLT   1'b1
`define STP_CLK_NS     10
`endif

// ==== hdl/stp_pkg.sv ====
/*
 Types shared by both ends: bus phase codes, state encodings and the
 odd parity helper. Assumes nothing beyond a SystemVerilog compiler.
*/
package stp_pkg;
	typedef enum logic [2:0] {
		PH_DOUT = 3'h0, PH_DIN = 3'h1, PH_CMD = 3'h2,
		PH_STAT = 3'h3, PH_MSGO = 3'h6, PH_MSGI = 3'h7
	} stp_phase_t;
	typedef enum logic [7:0] {
		T_FREE = 8'h01, T_MSGO = 8'h02, T_CMD = 8'h04, T_EXEC = 8'h08,
		T_DOUT = 8'h10, T_DIN = 8'h20, T_STAT = 8'h40, T_MSGI = 8'h80
	} stp_tst_t;
	typedef enum logic [3:0] {
		X_IDLE = 4'h1, X_SETUP = 4'h2, X_REQ = 4'h4, X_REL = 4'h8
	} stp_xst_t;
	typedef enum logic [2:0] {I_IDLE = 3'h1, I_SEL = 3'h2, I_CONN = 3'h4} stp_ist_t;
	typedef enum logic [1:0] {
		SRC_USER = 2'h0, SRC_SENSE = 2'h1, SRC_NOLUN = 2'h2, SRC_INQ = 2'h3
	} stp_src_t;
	// Odd parity bit for one bus byte
	function automatic logic stp_odd(input logic [7:0] b);
		return ~^b;
	endfunction
endpackage

// ==== hdl/stp_bus_if.sv ====
/*
 Parallel bus between target and initiator. Resolves the shared data
 and parity lines from both enables; idle lines read high. The user of
 the bus must drive parFlip: held low in use, high it inverts parity.
*/
`timescale 1ns/1ns
interface stp_bus_if;
	logic [2:0] phase;
	logic       req;
	logic       bsy;
	logic       tOe;
	logic       tPar;
	logic [7:0] tDat;
	logic       sel;
	logic       atn;
	logic       ack;
	logic       rst;
	logic       iOe;
	logic       iPar;
	logic [7:0] iDat;
	logic [7:0] dat;
	logic       par;
	logic       parFlip;
	// Terminated bus: nobody driving reads as all ones
	assign dat = tOe ? tDat : (iOe ? iDat : 8'hff);
	// Fault hook on the shared line, so both ends see the same bad byte
	assign par = (tOe ? tPar : (iOe ? iPar : 1'b1)) ^ parFlip;
	modport target (output phase, req, bsy, tOe, tPar, tDat,
		input sel, atn, ack, rst, dat, par);
	modport init (output sel, atn, ack, rst, iOe, iPar, iDat,
		input phase, req, bsy, dat, par);
endinterface

// ==== hdl/stp_initiator.sv ====
/*
 Initiator end: selects the target, answers each REQ, checks parity and
 drives recovery messages. Assumes the bus interface and a user side
 that supplies the CDB, the data-out bytes and takes data-in bytes.
*/
`timescale 1ns/1ns
`include "stp_consts.svh"
module stp_initiator import stp_pkg::*; #(
	parameter int RETRY_MAX = 8,
	parameter int DESKEW_NS = 45
) (
	input  wire logic        ref_clk,
	input  wire logic        nrst,
	stp_bus_if.init          bus,
	input  wire logic        startCmd,
	input  wire logic [47:0] cmdCdb,
	input  wire logic        useAtn,
	input  wire logic [2:0]  lun,
	input  wire logic        busRstReq,
	output logic [15:0]      outIdx,
	input  wire logic [7:0]  outByte,
	output logic             inValid,
	output logic [7:0]       inByte,
	output logic [15:0]      inIdx,
	output logic             done,
	output logic [7:0]       doneStat,
	output logic             doneErr,
	output logic             retryOvf,
	output logic             busy
);
	// ATN lead before the first ACK of a message: two deskew delays
	localparam int ATN_LEAD = (2 * DESKEW_NS + `STP_CLK_NS - 1) / `STP_CLK_NS;

	logic [13:0] s1_q, s2_q;
	logic        bsyS, reqS, parS, bad;
	logic [7:0]  datS;
	stp_phase_t  phS;
	stp_ist_t    st_q;
	logic [7:0]  cdb_q [6];
	logic [7:0]  msgOut_q, oDat_q;
	logic [2:0]  cptr_q;
	logic [15:0] dptr_q;
	logic [7:0]  lead_q, retries_q;
	logic        sel_q, atn_q, ack_q, drv_q, msgSys_q;

	////////////////////////////////////////////////////////////////////////
	// Target lines are asynchronous: two flops before use
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			s1_q <= '0;
			s2_q <= '0;
		end else begin
			s1_q <= {bus.bsy, bus.req, bus.phase, bus.par, bus.dat};
			s2_q <= s1_q;
		end
	end
	assign bsyS = s2_q[13];
	assign reqS = s2_q[12];
	assign phS  = stp_phase_t'(s2_q[11:9]);
	assign parS = s2_q[8];
	assign datS = s2_q[7:0];
	assign bad  = (parS != stp_odd(datS));

	////////////////////////////////////////////////////////////////////////
	// Connection and byte responder
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			st_q      <= I_IDLE;
			sel_q     <= 1'b0;
			atn_q     <= 1'b0;
			ack_q     <= 1'b0;
			drv_q     <= 1'b0;
			oDat_q    <= 8'h00;
			msgOut_q  <= 8'h00;
			msgSys_q  <= 1'b0;
			cptr_q    <= 3'h0;
			dptr_q    <= 16'h0000;
			lead_q    <= 8'h00;
			retries_q <= 8'h00;
			inValid   <= 1'b0;
			inByte    <= 8'h00;
			inIdx     <= 16'h0000;
			done      <= 1'b0;
			doneStat  <= 8'h00;
			doneErr   <= 1'b0;
			retryOvf  <= 1'b0;
			for (int i = 0; i < 6; i++) cdb_q[i] <= 8'h00;
		end else begin
			done    <= 1'b0;
			inValid <= 1'b0;
			if (lead_q != 8'h00) lead_q <= lead_q - 8'h01;
			case (st_q)
				I_IDLE: if (startCmd) begin
					for (int i = 0; i < 6; i++) cdb_q[i] <= cmdCdb[47 - 8 * i -: 8];
					msgSys_q  <= useAtn;
					atn_q     <= useAtn;
					lead_q    <= 8'(ATN_LEAD);
					msgOut_q  <= {5'h10, lun};
					sel_q     <= 1'b1;
					cptr_q    <= 3'h0;
					dptr_q    <= 16'h0000;
					retries_q <= 8'h00;
					doneErr   <= 1'b0;
					retryOvf  <= 1'b0;
					st_q      <= I_SEL;
				end
				I_SEL: if (bsyS) begin
					sel_q <= 1'b0;
					st_q  <= I_CONN;
				end
				I_CONN: if (!bsyS) begin
					done  <= 1'b1;
					atn_q <= 1'b0;
					ack_q <= 1'b0;
					drv_q <= 1'b0;
					st_q  <= I_IDLE;
				end else if (ack_q) begin
					if (!reqS) begin
						ack_q <= 1'b0;
						drv_q <= 1'b0;
					end
				end else if (reqS && phS[0]) begin
					ack_q <= 1'b1; // Every byte is taken, good or bad
					if (phS == PH_DIN) begin
						inValid <= 1'b1;
						inByte  <= datS;
						inIdx   <= dptr_q;
						dptr_q  <= dptr_q + 16'h0001;
					end
					if (phS == PH_STAT) doneStat <= datS;
					if (bad && !msgSys_q) doneErr <= 1'b1; // User reissues
					if (bad && msgSys_q) begin
						atn_q    <= 1'b1;
						lead_q   <= 8'(ATN_LEAD);
						msgOut_q <= (phS == PH_MSGI) ? `STP_MSG_MPE : `STP_MSG_IDE;
					end else if (phS == PH_MSGI && datS == `STP_MSG_RP) begin
						cptr_q    <= 3'h0;
						dptr_q    <= 16'h0000;
						retries_q <= retries_q + 8'h01;
						if (retries_q >= 8'(RETRY_MAX)) begin
							atn_q    <= 1'b1; // Give up with an abort
							lead_q   <= 8'(ATN_LEAD);
							msgOut_q <= `STP_MSG_ABT;
							retryOvf <= 1'b1;
						end
					end
				end else if (reqS && !drv_q) begin
					drv_q <= 1'b1; // Data settles a cycle before ACK
					case (phS)
						PH_CMD:  oDat_q <= cdb_q[cptr_q];
						PH_DOUT: oDat_q <= outByte;
						default: oDat_q <= msgOut_q; // Same byte on every retry
					endcase
				end else if (reqS && (phS != PH_MSGO || lead_q == 8'h00)) begin
					ack_q <= 1'b1;
					if (phS == PH_CMD) cptr_q <= cptr_q + 3'h1;
					if (phS == PH_DOUT) dptr_q <= dptr_q + 16'h0001;
					if (phS == PH_MSGO) atn_q <= 1'b0; // Single byte: ATN ends with it
				end
				default: st_q <= I_IDLE;
			endcase
		end
	end

	assign outIdx   = dptr_q;
	assign busy     = (st_q != I_IDLE);
	assign bus.sel  = sel_q;
	assign bus.atn  = atn_q;
	assign bus.ack  = ack_q;
	assign bus.rst  = busRstReq;
	assign bus.iOe  = drv_q;
	assign bus.iDat = oDat_q;
	assign bus.iPar = stp_odd(oDat_q);
endmodule

// ==== verification/stp_link_chk.sv ====
/*
 Concurrent checks on the bus between target and initiator.
 Assumes the bench hands every watched interface signal in by name.
*/
`timescale 1ns/1ns
module stp_link_chk import stp_pkg::*; (
	input logic       ref_clk,
	input logic       nrst,
	input logic [2:0] phase,
	input logic       req,
	input logic       bsy,
	input logic       sel,
	input logic       atn,
	input logic       ack,
	input logic       tOe,
	input logic       tPar,
	input logic [7:0] tDat,
	input logic       iOe,
	input logic       iPar,
	input logic [7:0] iDat
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	////////////////////////////////////////////////////////////////////
	// Byte steps that open the closing part of a command
	sequence sStat; phase == PH_STAT && req ##1 !req; endsequence
	sequence sCc; phase == PH_MSGI && req && tDat == 8'h00 ##1 !req; endsequence
	// Odd parity on whatever either end drives
	tpar_odd_a: assert property (tOe && req |-> tPar == ~^tDat)
		else $error("target parity not odd");
	ipar_odd_a: assert property (iOe && ack |-> iPar == ~^iDat)
		else $error("initiator parity not odd");
	// Interlock: data held until ack, ack only against req
	data_hold_a: assert property (tOe && req && !ack |=> $stable(tDat))
		else $error("target data moved before ack");
	ack_req_a: assert property ($rose(ack) |-> req)
		else $error("ack without req");
	sel_bsy_a: assert property ($rose(bsy) |-> sel)
		else $error("busy without selection");
	// Lead of atn before the first message ack
	atn_lead_a: assert property ($rose(ack) && phase == PH_MSGO |-> $past(atn, 2))
		else $error("message ack without atn lead");
	stat_cc_a: assert property (sStat |-> ##[1:60] (req && phase == PH_MSGI && tDat == 8'h00))
		else $error("status not followed by completion");
	cc_free_a: assert property (sCc |-> ##[1:30] !bsy)
		else $error("no bus free after completion");
endmodule

// ==== verification/scsi_target_parity_recovery_test.sv ====
/*
 Bench joining both ends through the bus interface; drives both user
 sides on falling edges. Assumes the design files under hdl/.
*/
`timescale 1ns/1ns
`include "stp_consts.svh"
module scsi_target_parity_recovery_test;
	logic        ref_clk, nrst, hwParOpt, modeParWe, modeParVal, startCmd;
	logic        useAtn, rspValid, rChk, parChkOn, cmdValid, doutValid, inValid, done;
	logic        flipDout, doutRestart, retryOvf;
	logic [2:0]  lun;
	logic [47:0] cdb, tCdb;
	logic [1:0]  rDir;
	logic [3:0]  rKey;
	logic [15:0] rLen, dinIdx, doutIdx, outIdx, inIdx;
	logic [7:0]  rAsc, rAscq, dinByte, doutByte, outByte, inByte, doneStat;
	logic [7:0]  got [16];
	int          errors, compares, nIn, nOut, nCmd, nRestart;
	stp_bus_if bus ();
	stp_target u_stp_target (.ref_clk(ref_clk), .nrst(nrst), .bus(bus),
		.hwParOpt(hwParOpt), .modeParWe(modeParWe), .modeParVal(modeParVal),
		.parChkOn(parChkOn), .cmdValid(cmdValid), .cmdCdb(tCdb), .rspValid(rspValid),
		.rspDir(rDir), .rspLen(rLen), .rspCheck(rChk), .rspKey(rKey), .rspAsc(rAsc),
		.rspAscq(rAscq), .dinIdx(dinIdx), .dinByte(dinByte), .doutValid(doutValid),
		.doutByte(doutByte), .doutIdx(doutIdx), .doutRestart(doutRestart));
	stp_initiator #(.RETRY_MAX(2)) u_stp_initiator (.ref_clk(ref_clk), .nrst(nrst),
		.bus(bus), .startCmd(startCmd), .cmdCdb(cdb), .useAtn(useAtn), .lun(lun),
		.busRstReq(1'b0), .outIdx(outIdx), .outByte(outByte), .inValid(inValid),
		.inByte(inByte), .inIdx(inIdx), .done(done), .doneStat(doneStat),
		.doneErr(), .retryOvf(retryOvf), .busy());
	stp_link_chk u_stp_link_chk (.ref_clk(ref_clk), .nrst(nrst), .phase(bus.phase),
		.req(bus.req), .bsy(bus.bsy), .sel(bus.sel), .atn(bus.atn), .ack(bus.ack),
		.tOe(bus.tOe), .tPar(bus.tPar), .tDat(bus.tDat), .iOe(bus.iOe),
		.iPar(bus.iPar), .iDat(bus.iDat));
	////////////////////////////////////////////////////////////////////
	// User-side data patterns, distinct per direction
	assign dinByte = dinIdx[7:0] ^ 8'h5a;
	assign outByte = outIdx[7:0] + 8'h30;
	// Bad parity on data-out bytes until the command's first restart
	assign bus.parFlip = flipDout && bus.bsy && bus.phase == 3'h0 && nRestart == 0;
	initial begin
		ref_clk = 0;
		forever #5 ref_clk = ~ref_clk;
	end
	// Executor answers each command once, one cycle later
	always @(negedge ref_clk) rspValid <= (cmdValid === 1'b1);
	// Capture mid-cycle, where registered outputs have settled
	always @(negedge ref_clk) begin
		if (doutRestart === 1'b1) nRestart++;
		if (inValid === 1'b1) begin
			got[inIdx[3:0]] = inByte;
			nIn++;
		end
		if (doutValid === 1'b1) begin
			nOut++;
			chk("dout", {8'h0, doutIdx[7:0] + 8'h30}, {8'h0, doutByte});
		end
		if (cmdValid === 1'b1) nCmd++;
	end
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
		compares++;
		if (s !== e) begin
			errors++;
			$display("[ERR] %s exp %h got %h", nm, e, s);
		end
	endtask
	task test_done;
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	// One whole command; a hang counts as a mismatch
	task automatic run(input string nm, input logic [7:0] op, input logic [2:0] cl,
		input logic a, input logic [2:0] l, input logic [7:0] st);
		int i;
		cdb = {op, cl, 37'h0};
		useAtn = a;
		lun = l;
		nIn = 0;
		nOut = 0;
		nRestart = 0;
		startCmd = 1;
		@(negedge ref_clk);
		startCmd = 0;
		for (i = 0; i < 4000 && done !== 1'b1; i++) @(negedge ref_clk);
		if (done !== 1'b1) begin
			errors++;
			test_done;
		end
		chk({nm, " stat"}, {8'h0, st}, {8'h0, doneStat});
		$display("test %s done", nm);
		repeat (3) @(negedge ref_clk);
	endtask
	task automatic par(input logic o, input logic w, input logic v, input logic e);
		hwParOpt = o;
		modeParWe = w;
		modeParVal = v;
		@(negedge ref_clk);
		modeParWe = 0;
		repeat (4) @(negedge ref_clk);
		chk("parChkOn", {15'h0, e}, {15'h0, parChkOn});
	endtask
	////////////////////////////////////////////////////////////////////
	initial begin
		{nrst, modeParWe, startCmd, useAtn, rChk, lun, cdb, rDir, rLen} = '0;
		{rKey, rAsc, rAscq} = '0;
		{hwParOpt, modeParVal} = 2'h3;
		{errors, compares, nIn, nOut, nCmd, nRestart} = '0;
		flipDout = 0;
		repeat (3) @(negedge ref_clk);
		nrst = 1;
		par(1, 0, 1, 1);
		par(0, 0, 1, 0);
		par(1, 1, 0, 0);
		par(1, 1, 1, 1);
		rDir = 2'h1;
		rLen = 16'h0003;
		run("din", 8'h08, 3'h0, 1, 3'h0, `STP_ST_GOOD);
		chk("din n", 16'h0003, nIn[15:0]);
		chk("din b1", 16'h005b, {8'h0, got[1]});
		rDir = 2'h2;
		rLen = 16'h0004;
		run("dout", 8'h0a, 3'h0, 0, 3'h0, `STP_ST_GOOD);
		chk("dout n", 16'h0004, nOut[15:0]);
		rDir = 2'h0;
		run("ovr", 8'h00, 3'h2, 1, 3'h0, `STP_ST_GOOD);
		chk("ovr cmds", 16'h0003, nCmd[15:0]);
		{rChk, rKey, rAsc, rAscq} = {1'b1, 4'h3, 8'h11, 8'h01};
		run("chk", 8'h1b, 3'h0, 1, 3'h0, `STP_ST_CHK);
		rChk = 0;
		run("inq", `STP_OP_INQ, 3'h0, 1, 3'h2, `STP_ST_GOOD);
		chk("inq n", `STP_INQ_LEN, nIn[15:0]);
		chk("inq b0", {8'h0, `STP_INQ_NOLUN}, {8'h0, got[0]});
		run("bad", 8'h08, 3'h2, 0, 3'h0, `STP_ST_CHK);
		chk("bad cmds", 16'h0004, nCmd[15:0]);
		run("nsn", `STP_OP_SENSE, 3'h2, 0, 3'h0, `STP_ST_GOOD);
		chk("nsn n", `STP_SNS_LEN, nIn[15:0]);
		chk("nsn key", 16'h0005, {8'h0, got[2]});
		chk("nsn asc", {`STP_ASC_LUN, `STP_ASCQ_NONE}, {got[12], got[13]});
		run("sn0", `STP_OP_SENSE, 3'h0, 0, 3'h0, `STP_ST_GOOD);
		chk("sn0 key", 16'h0003, {8'h0, got[2]});
		chk("sn0 asc", 16'h1101, {got[12], got[13]});
		rDir = 2'h2;
		rLen = 16'h0004;
		flipDout = 1;
		run("pe0", 8'h0a, 3'h0, 0, 3'h0, `STP_ST_CHK);
		chk("pe0 n", 16'h0004, nOut[15:0]);
		run("pe1", 8'h0a, 3'h0, 1, 3'h0, `STP_ST_GOOD);
		chk("pe1 n", 16'h0008, nOut[15:0]);
		chk("pe1 rst", 16'h0001, nRestart[15:0]);
		chk("pe1 ovf", 16'h0000, {15'h0, retryOvf});
		flipDout = 0;
		run("sn1", `STP_OP_SENSE, 3'h0, 0, 3'h0, `STP_ST_GOOD);
		chk("sn1 key", {12'h0, `STP_KEY_HW}, {8'h0, got[2]});
		chk("sn1 asc", {`STP_ASC_PAR, `STP_ASCQ_NONE}, {got[12], got[13]});
		run("sn2", `STP_OP_SENSE, 3'h0, 0, 3'h0, `STP_ST_GOOD);
		chk("sn2 key", 16'h0000, {8'h0, got[2]});
		test_done;
	end
endmodule
